// [common/via_pkg.sv]
package via_pkg;
	localparam int NUM_SRC = 14;
	localparam logic [14:0] ISR_ENTRY_ADDR = 15'h00ff;
	localparam logic [7:0] VEC_BASE_LOW = 8'he0;
	localparam logic [7:0] VEC_TRAP_LOW = 8'hfe;
	localparam int ACK_CYCLES = 7;
	localparam logic [2:0] ACK_LAST = 3'h6;
	localparam logic [3:0] ADDR_PEND_LO = 4'h0;
	localparam logic [3:0] ADDR_PEND_HI = 4'h1;
	localparam logic [3:0] ADDR_EN_LO = 4'h2;
	localparam logic [3:0] ADDR_EN_HI = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_VECLOW = 4'h5;
	localparam int STAT_GIE_BIT = 0;
	localparam int STAT_TRAP_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam logic [15:0] PEND_RESET = 16'h0000;
	localparam logic [15:0] EN_RESET = 16'h0000;

	typedef struct packed {
		logic instr_start;
		logic skip;
		logic [14:0] next_pc;
		logic vis_exec;
		logic [14:0] vis_pc;
		logic return_from_interrupt_exec;
		logic trap_exec;
		logic clr_trap_exec;
		logic gie_write;
		logic gie_wdata;
	} via_seq_type;

	typedef struct packed {
		logic ack_start;
		logic ack_busy;
		logic push_valid;
		logic [14:0] push_addr;
		logic pc_load;
		logic [14:0] pc_value;
	} via_ctl_type;
endpackage

// [core/via_arbiter.sv]
`timescale 1ns/10ps
// Functional notes
// - Every acknowledge branches to 00FF.
// - Trap non-maskable and top; default lowest.
// - Each source has enable and pending.
// - Pending and enable bits are software accessible.
// - Request needs enable, global enable, no trap.
// - Sample at instruction start; highest rank wins.
// - Reset clears pending, enables, global enable.
// - Enabling an already pending source fires immediately.
// - Mid-instruction requests wait; skip happens first.
// - Acknowledge clears global enable, pushes, jumps, seven cycles.
// - Software may reenable globally for nesting.
// - Return sets global enable and pops.
// - Vector select takes highest enabled pending.
// - Table tops block, or next block.
// - Vectors fifteen bits, high byte first.
// - Slots ascend E0 up to trap FE.
// - Nothing active selects default E0 slot.
// - Arbitration gives even low byte E0..FE.
// - Trap flag cleared only by instruction, reset.
module via_arbiter (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Avalon-MM register slave.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_response_err,
	// Maskable source events, bit 0 lowest rank; synchronised here.
	input wire logic [via_pkg::NUM_SRC-1:0] src_event,
	// Sequencer side.
	input via_pkg::via_seq_type seq,
	output via_pkg::via_ctl_type ctl,
	output logic [7:0] vis_low_byte,
	output logic [14:0] vis_table_addr,
	output logic global_interrupt_enable,
	output logic trap_pending_flag,
	output logic irq_request
);
	// Only two states are needed: the acknowledge runs as a fixed count inside one state.
	// The two unused codes fall back to idle.
	typedef enum logic [1:0] {
		VIA_IDLE = 2'b00,
		VIA_ACK = 2'b01
	} via_state_type;

	via_state_type state_r;
	via_state_type state_nxt;
	logic [2:0] ack_cnt_r;
	logic [2:0] ack_cnt_nxt;
	logic [via_pkg::NUM_SRC-1:0] sync1_r;
	logic [via_pkg::NUM_SRC-1:0] sync2_r;
	logic [via_pkg::NUM_SRC-1:0] prev_r;
	logic [via_pkg::NUM_SRC-1:0] pend_r;
	logic [via_pkg::NUM_SRC-1:0] pend_nxt;
	logic [via_pkg::NUM_SRC-1:0] en_r;
	logic [via_pkg::NUM_SRC-1:0] en_nxt;
	logic gie_r;
	logic gie_nxt;
	logic trap_r;
	logic trap_nxt;
	logic [14:0] push_addr_r;
	logic [14:0] push_addr_nxt;
	logic [7:0] vis_low_r;
	logic [14:0] vis_addr_r;
	logic [31:0] rdata_r;
	logic rvalid_r;
	logic err_r;

	// Slot low byte of the winner among active sources; slot 0 is the default vector.
	// The loop runs upward, so the highest active rank is the one left standing.
	function automatic logic [7:0] via_pick(input logic trap,
		input logic [via_pkg::NUM_SRC-1:0] act);
		logic [7:0] low;
		low = via_pkg::VEC_BASE_LOW;
		for (int i = 0; i < via_pkg::NUM_SRC; i++) begin
			if (act[i]) begin
				low = via_pkg::VEC_BASE_LOW + 8'((i + 1) * 2);
			end
		end
		if (trap) begin
			low = via_pkg::VEC_TRAP_LOW;
		end
		return low;
	endfunction

	// Address decode shared by every register strobe.
	function automatic logic via_hit(input logic [3:0] addr, input logic [3:0] reg_addr);
		return addr == reg_addr;
	endfunction

	// Read view of the register file; unmapped words read as zero.
	function automatic logic [31:0] via_rmux(input logic [3:0] addr,
		input logic [15:0] pend, input logic [15:0] en, input logic [2:0] stat,
		input logic [7:0] vlow);
		logic [31:0] word;
		word = 32'h0000_0000;
		unique case (addr)
			via_pkg::ADDR_PEND_LO: word = {24'h00_0000, pend[7:0]};
			via_pkg::ADDR_PEND_HI: word = {24'h00_0000, pend[15:8]};
			via_pkg::ADDR_EN_LO: word = {24'h00_0000, en[7:0]};
			via_pkg::ADDR_EN_HI: word = {24'h00_0000, en[15:8]};
			via_pkg::ADDR_STATUS: word = {29'h0000_0000, stat};
			via_pkg::ADDR_VECLOW: word = {24'h00_0000, vlow};
			default: word = 32'h0000_0000;
		endcase
		return word;
	endfunction

	// Combinational decode, one named wire per decision.
	logic [via_pkg::NUM_SRC-1:0] src_rise;
	logic [via_pkg::NUM_SRC-1:0] active;
	logic mask_ok;
	logic want_irq;
	logic in_ack;
	logic take_ack;
	logic ack_done;
	logic bus_req;
	logic bus_take;
	logic bus_wr;
	logic bus_rd;
	logic wr_pend_lo;
	logic wr_pend_hi;
	logic wr_en_lo;
	logic wr_en_hi;
	logic wr_stat;
	logic addr_ok;
	logic [15:0] pend_w;
	logic [15:0] en_w;
	logic [2:0] stat_w;
	logic [31:0] rd_word;
	logic [14:0] vis_next;
	logic [7:0] pick_low;

	// A held source level sets its pending flag only once, on the rising edge.
	assign src_rise = sync2_r & ~prev_r;
	assign active = pend_r & en_r;
	// The trap instruction is acknowledged by the sequencer itself, so the trap flag only
	// masks the maskable sources here. Requesting on it as well would re-enter its service
	// routine at every instruction start until the flag is cleared.
	assign mask_ok = gie_r & ~trap_r;
	assign want_irq = |active & mask_ok;
	assign in_ack = (state_r == VIA_ACK);
	assign take_ack = seq.instr_start & ~seq.skip & want_irq & ~in_ack;
	assign ack_done = in_ack && (ack_cnt_r == via_pkg::ACK_LAST);

	// A request is accepted at the edge that ends the cycle after its single wait cycle. Writes act only
	// there, so a write held through its wait cycle is never applied twice.
	assign bus_req = avs_read | avs_write;
	assign bus_take = bus_req & rvalid_r;
	assign bus_wr = avs_write & ~avs_read & bus_take;
	assign bus_rd = avs_read & ~avs_write;
	assign wr_pend_lo = bus_wr && via_hit(avs_address, via_pkg::ADDR_PEND_LO);
	assign wr_pend_hi = bus_wr && via_hit(avs_address, via_pkg::ADDR_PEND_HI);
	assign wr_en_lo = bus_wr && via_hit(avs_address, via_pkg::ADDR_EN_LO);
	assign wr_en_hi = bus_wr && via_hit(avs_address, via_pkg::ADDR_EN_HI);
	assign wr_stat = bus_wr && via_hit(avs_address, via_pkg::ADDR_STATUS);
	assign addr_ok = (avs_address <= via_pkg::ADDR_VECLOW);
	// Unused upper bits of the 16-bit views read as zero.
	assign pend_w = {2'h0, pend_r};
	assign en_w = {2'h0, en_r};
	assign stat_w = {in_ack, trap_r, gie_r};
	assign rd_word = via_rmux(avs_address, pend_w, en_w, stat_w, vis_low_r);
	// Block of the next byte after the select instruction, so a select at xxFF uses the next block.
	assign vis_next = seq.vis_pc + 15'h0001;
	assign pick_low = via_pick(trap_r, active);

	// Handshake outputs are combinational; data outputs come straight from flip-flops.
	assign avs_waitrequest = bus_req & ~rvalid_r;
	assign avs_readdata = rdata_r;
	assign avs_response_err = err_r;
	assign global_interrupt_enable = gie_r;
	assign trap_pending_flag = trap_r;
	assign irq_request = want_irq;
	assign vis_low_byte = vis_low_r;
	assign vis_table_addr = vis_addr_r;
	// The whole control word is driven by one assignment so the struct has a single driver.
	assign ctl = '{ack_start: take_ack, ack_busy: in_ack, push_valid: ack_done,
		push_addr: push_addr_r, pc_load: ack_done, pc_value: via_pkg::ISR_ENTRY_ADDR};

	// Software writes replace a whole byte of flags at once.
	// A software clear of a flag that rises in the same cycle is lost on purpose.
	always_comb begin
		pend_nxt = pend_r;
		if (wr_pend_lo) begin
			pend_nxt[7:0] = avs_writedata[7:0];
		end
		if (wr_pend_hi) begin
			pend_nxt[via_pkg::NUM_SRC-1:8] = avs_writedata[via_pkg::NUM_SRC-9:0];
		end
		// Hardware set wins over a software clear in the same cycle.
		pend_nxt = pend_nxt | src_rise;
	end

	// Enables change only by software; hardware never touches them.
	always_comb begin
		en_nxt = en_r;
		if (wr_en_lo) begin
			en_nxt[7:0] = avs_writedata[7:0];
		end
		if (wr_en_hi) begin
			en_nxt[via_pkg::NUM_SRC-1:8] = avs_writedata[via_pkg::NUM_SRC-9:0];
		end
	end

	// Later statements win, so the acknowledge clear beats a return or a status write.
	always_comb begin
		gie_nxt = gie_r;
		if (wr_stat) begin
			gie_nxt = avs_writedata[via_pkg::STAT_GIE_BIT];
		end
		if (seq.gie_write) begin
			gie_nxt = seq.gie_wdata;
		end
		if (seq.return_from_interrupt_exec) begin
			gie_nxt = 1'b1;
		end
		if (take_ack) begin
			gie_nxt = 1'b0;
		end
	end

	// Leaving idle needs an accepted request; leaving the acknowledge needs the last count.
	// No new request can be taken while the acknowledge is running.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			VIA_IDLE: begin
				if (take_ack) begin
					state_nxt = VIA_ACK;
				end
			end
			VIA_ACK: begin
				if (ack_done) begin
					state_nxt = VIA_IDLE;
				end
			end
			default: begin
				state_nxt = VIA_IDLE;
			end
		endcase
	end

	// Setting the trap flag wins over its clear instruction in the same cycle.
	always_comb begin
		trap_nxt = trap_r;
		if (seq.clr_trap_exec) begin
			trap_nxt = 1'b0;
		end
		if (seq.trap_exec) begin
			trap_nxt = 1'b1;
		end
	end

	// Two stages before any logic reads the sources; prev_r only feeds the edge detector.
	// The chain holds nothing software can see, so it needs no reset.
	always_ff @(posedge clock) begin
		sync1_r <= src_event;
		sync2_r <= sync1_r;
		prev_r <= sync2_r;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pend_r <= '0;
			en_r <= '0;
			gie_r <= 1'b0;
			trap_r <= 1'b0;
			state_r <= VIA_IDLE;
		end else begin
			pend_r <= pend_nxt;
			en_r <= en_nxt;
			gie_r <= gie_nxt;
			state_r <= state_nxt;
			trap_r <= trap_nxt;
		end
	end

	// The counter moves only during the acknowledge, so it cannot wrap into a second load.
	always_comb begin
		ack_cnt_nxt = ack_cnt_r;
		push_addr_nxt = push_addr_r;
		if (take_ack) begin
			ack_cnt_nxt = 3'h0;
			push_addr_nxt = seq.next_pc;
		end else if (in_ack) begin
			ack_cnt_nxt = ack_cnt_r + 3'h1;
		end
	end

	// The return address is held for the whole acknowledge and stands at the push.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ack_cnt_r <= 3'h0;
			push_addr_r <= 15'h0000;
		end else begin
			ack_cnt_r <= ack_cnt_nxt;
			push_addr_r <= push_addr_nxt;
		end
	end

	// Arbitration is sampled in the select instruction's first cycle only.
	// Later changes of pending or enable bits do not move a table address already given.
	// The last slot byte stays readable for software that wants to see what was chosen.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			vis_low_r <= via_pkg::VEC_BASE_LOW;
			vis_addr_r <= 15'h0000;
		end else if (seq.vis_exec) begin
			vis_low_r <= pick_low;
			vis_addr_r <= {vis_next[14:8], pick_low};
		end
	end

	// One wait cycle on every access keeps read data registered.
	// The word is captured in the wait cycle and stands at the accepting edge; the error
	// flag follows the same timing so a master sees both together.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			rvalid_r <= bus_req & ~rvalid_r;
			err_r <= bus_req & ~addr_ok;
			rdata_r <= 32'h0000_0000;
			if (bus_rd) begin
				rdata_r <= rd_word;
			end
		end
	end
endmodule

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0, rdat, avs_readdata;
	logic [13:0] src_event = 14'h0;
	logic [2:0] op = 3'h0;
	logic [14:0] pc = 15'h0000, pc_r, vis_table_addr;
	logic [7:0] vis_low_byte;
	logic avs_waitrequest, avs_response_err, global_interrupt_enable;
	logic trap_pending_flag, irq_request, rerr;
	via_pkg::via_seq_type seq;
	via_pkg::via_ctl_type ctl;
	int fails = 0, checked = 0, cyc = 0;
	via_arbiter DUT (.*);
	via_seq_model seqm (.*);
	always #5 clock = ~clock;
	task results;
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			results();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
		avs_address <= ad;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		rerr = avs_response_err;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task rd(input logic [3:0] ad, input logic [31:0] e);
		bus(1'b0, ad, 32'h0);
		chk("readdata", e, rdat);
	endtask
	// Ends after the pulse has been taken, with updates settled.
	task cmd(input logic [2:0] o);
		op <= o;
		@(posedge clock);
		op <= 3'h0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 5; i++) rd(4'(i), 32'h0);
		rd(4'h7, 32'h0);
		chk("err", 1'b1, rerr);
		src_event <= 14'h2009;
		repeat (5) @(posedge clock);
		src_event <= 14'h0;
		repeat (5) @(posedge clock);
		rd(4'h0, 32'h09);
		rd(4'h1, 32'h20);
		pc <= 15'h00ff;
		cmd(3'h1);
		chk("slot", 8'he0, vis_low_byte);
		chk("table", 15'h01e0, vis_table_addr);
		bus(1'b1, 4'h3, 32'h20);
		bus(1'b1, 4'h2, 32'h09);
		bus(1'b1, 4'h4, 32'h1);
		#1 chk("irq", 1'b1, irq_request);
		pc <= 15'h0234;
		cmd(3'h1);
		chk("slot", 8'hfc, vis_low_byte);
		chk("table", 15'h02fc, vis_table_addr);
		cmd(3'h5);
		chk("busy", 1'b0, ctl.ack_busy);
		pc <= 15'h0456;
		cmd(3'h4);
		chk("busy", 1'b1, ctl.ack_busy);
		chk("gie", 1'b0, global_interrupt_enable);
		repeat (8) @(posedge clock);
		#1 chk("pc", 15'h00ff, pc_r);
		chk("push", 15'h0456, ctl.push_addr);
		bus(1'b1, 4'h1, 32'h0);
		cmd(3'h2);
		chk("gie", 1'b1, global_interrupt_enable);
		chk("irq", 1'b1, irq_request);
		cmd(3'h3);
		chk("trap", 1'b1, trap_pending_flag);
		chk("irq", 1'b0, irq_request);
		pc <= 15'h03ff;
		cmd(3'h1);
		chk("slot", 8'hfe, vis_low_byte);
		chk("table", 15'h04fe, vis_table_addr);
		cmd(3'h6);
		chk("trap", 1'b0, trap_pending_flag);
		rd(4'h4, 32'h1);
		chk("err", 1'b0, rerr);
		cmd(3'h7);
		chk("irq", 1'b0, irq_request);
		results();
	end
endmodule

// [test/via_arbiter_sva.sv]
`timescale 1ns/10ps
module via_arbiter_sva (
	// Watched ports.
	input wire logic clock,
	input wire logic rst_b,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input via_pkg::via_seq_type seq,
	input via_pkg::via_ctl_type ctl,
	input wire logic [7:0] vis_low_byte,
	input wire logic [14:0] vis_table_addr,
	input wire logic global_interrupt_enable,
	input wire logic trap_pending_flag,
	input wire logic irq_request
);
	logic [14:0] pc_q;
	always_ff @(posedge clock) begin
		pc_q <= seq.vis_pc;
	end
	wire [6:0] blk_w = pc_q[14:8] + 7'(pc_q[7:0] == 8'hff);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence ack_s;
		ctl.ack_busy [*7];
	endsequence
	entry_addr_a: assert property (ctl.pc_load |-> ctl.pc_value == 15'h00ff)
		else $error("entry address wrong");
	ack_busy_a: assert property (ctl.ack_start |=> ack_s)
		else $error("acknowledge length wrong");
	ack_push_a: assert property (ctl.ack_start |-> ##7 ctl.push_valid && ctl.pc_load)
		else $error("push or load missing");
	ack_gie_a: assert property (ctl.ack_start |=> !global_interrupt_enable)
		else $error("global enable kept");
	ack_cause_a: assert property (ctl.ack_start |-> seq.instr_start && !seq.skip && irq_request)
		else $error("acknowledge without cause");
	irq_gate_a: assert property (irq_request |-> global_interrupt_enable && !trap_pending_flag)
		else $error("request while masked");
	return_from_interrupt_gie_a: assert property (seq.return_from_interrupt_exec && !ctl.ack_start |=> global_interrupt_enable)
		else $error("return left enable low");
	trap_set_a: assert property (seq.trap_exec |=> trap_pending_flag)
		else $error("trap flag not set");
	trap_hold_a: assert property (trap_pending_flag && !seq.clr_trap_exec |=> $stable(trap_pending_flag))
		else $error("trap flag dropped");
	vis_even_a: assert property (seq.vis_exec |=> !vis_low_byte[0] && vis_low_byte >= 8'he0)
		else $error("slot byte out of range");
	vis_table_a: assert property (seq.vis_exec |=> vis_table_addr == {blk_w, vis_low_byte})
		else $error("table address wrong");
	bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
endmodule
bind via_arbiter via_arbiter_sva chk (.*);

// [test/via_seq_model.sv]
`timescale 1ns/10ps
module via_seq_model (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Bench command and core control.
	input wire logic [2:0] op,
	input wire logic [14:0] pc,
	input via_pkg::via_ctl_type ctl,
	// Sequencer strobes and program counter.
	output via_pkg::via_seq_type seq,
	output logic [14:0] pc_r
);
	// No instruction starts while the core is busy acknowledging.
	always_ff @(posedge clock) begin
		seq.next_pc <= pc;
		seq.vis_pc <= pc;
		seq.instr_start <= (op == 3'h4 || op == 3'h5) && !ctl.ack_busy;
		seq.skip <= op == 3'h5;
		seq.vis_exec <= op == 3'h1;
		seq.return_from_interrupt_exec <= op == 3'h2;
		seq.trap_exec <= op == 3'h3;
		seq.clr_trap_exec <= op == 3'h6;
		seq.gie_write <= op == 3'h7;
		seq.gie_wdata <= 1'b0;
		if (!rst_b) begin
			pc_r <= 15'h0000;
		end else if (ctl.pc_load) begin
			pc_r <= ctl.pc_value;
		end
	end
endmodule
